//--- inc/dcd_pkg.sv
// package for the converter and digital I/O register block
// assumes an 8-bit host port with byte offsets and one 40 MHz clock
package dcd_pkg;
    localparam logic [7:0] OFF_CARD_RESET = 8'h00;
    localparam logic [7:0] OFF_CONV_DATA  = 8'hd0;
    localparam logic [7:0] OFF_CONV_HIGH  = 8'hd4;
    localparam logic [7:0] OFF_LINES_LOW  = 8'hd8;
    localparam logic [7:0] OFF_LINES_HIGH = 8'hdc;
    localparam logic [7:0] OFF_GAIN_CHAN  = 8'he0;
    localparam logic [7:0] OFF_TRIG_MODE  = 8'he4;
    localparam logic [7:0] OFF_SW_TRIGGER = 8'he8;
    localparam logic [7:0] OFF_CONV_STAT  = 8'hec;

    localparam int SAMPLE_W = 12;
    localparam int LINES_W  = 16;
    localparam int GAIN_LSB = 0;
    localparam int CHAN_LSB = 2;
    localparam int SW_BIT   = 0;
    localparam int PACE_BIT = 1;
    localparam int RDY_BIT  = 0;
    localparam int RST_BIT  = 0;
    localparam int TRIG_BIT = 0;

    // gain factors per code for the two variants
    localparam logic [9:0] GAIN_LO_TAB [4] = '{10'd1, 10'd2, 10'd4, 10'd8};
    localparam logic [9:0] GAIN_HI_TAB [4] =
        '{10'd1, 10'd10, 10'd100, 10'd1000};

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcd_bus_t;

    typedef struct packed {
        logic [1:0] gain;
        logic [3:0] chan;
    } dcd_sel_t;
endpackage

//--- design/dcd_conv_ctl.sv
// conversion start and ready-flag control
// assumes done and pacer pulses are already synchronous to i_clk
`timescale 1ns/1ps
module dcd_conv_ctl
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // mode and trigger sources
    input  wire logic        i_sw_mode,
    input  wire logic        i_pace_mode,
    input  wire logic        i_sw_trig,
    input  wire logic        i_pace_pulse,
    input  wire logic        i_done,
    // outputs
    output logic             o_start,
    output logic             o_ready
);
    typedef struct packed {
        logic start;
        logic ready;
        logic busy;
    } dcd_cc_st_t;

    dcd_cc_st_t st_q;
    dcd_cc_st_t st_d;
    logic       go;

    always_comb
    begin
        st_d       = st_q;
        // a new start is refused while one is still running
        go         = !st_q.busy && ((i_sw_mode && i_sw_trig) ||
                     (i_pace_mode && i_pace_pulse));
        st_d.start = go;
        if (go)
        begin
            st_d.busy  = 1'b1;
            st_d.ready = 1'b0;
        end
        else if (st_q.busy && i_done)
        begin
            st_d.busy  = 1'b0;
            st_d.ready = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_start = st_q.start;
    assign o_ready = st_q.ready;

    start_one_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_start |-> !o_ready ##0 !$past(st_q.busy))
        else $error("start issued while busy or ready");
    ready_done_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q.busy && i_done && !go) |=> o_ready)
        else $error("ready not raised after done");
    ready_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_q.busy |-> !o_ready)
        else $error("ready rose during conversion");
    sw_ignored_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!i_sw_mode && !i_pace_mode) |=> !o_start)
        else $error("start with no mode enabled");
    c_sw: cover property (@(posedge i_clk) i_sw_mode && i_sw_trig ##1 o_start);
    c_pace: cover property (@(posedge i_clk)
        i_pace_mode && i_pace_pulse ##1 o_start);
    c_done: cover property (@(posedge i_clk) o_start ##[1:20] o_ready);
endmodule

//--- design/dcd_regs.sv
// host register block of a data acquisition card
// assumes a synchronous 8-bit host port (address, read and write strobes)
`timescale 1ns/1ps
module dcd_regs
#(
    parameter bit HIGH_GAIN = 1'b0
)
(
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    // host port
    input  wire dcd_pkg::dcd_bus_t   i_bus,
    output logic [7:0]               o_rdata,
    // converter side
    input  wire logic [11:0]         i_sample_bits,
    input  wire logic                i_conv_done,
    input  wire logic                i_pacer,
    input  wire logic                i_diff_mode,
    output logic                     o_conv_start,
    output logic [11:0]              o_dac_code,
    output logic [3:0]               o_input_channel_select,
    output logic                     o_amp_gain_sel_hi,
    output logic                     o_amp_gain_sel_lo,
    output logic [9:0]               o_gain_factor,
    // digital lines
    input  wire logic [15:0]         i_in_lines,
    output logic [15:0]              o_out_lines
);
    typedef struct packed {
        logic [7:0]  rdata;
        logic [11:0] result;
        logic [7:0]  dac_stage;
        logic [11:0] dac_code;
        logic [15:0] out_lines;
        logic [5:0]  sel;
        logic [1:0]  mode;
        logic        card_run;
        logic [3:0]  chan_eff;
        logic [9:0]  gain_f;
        logic        sw_trig;
        logic [1:0]  pace_s;
        logic        pace_last;
        logic [1:0]  done_s;
        logic        done_last;
        logic [15:0] in_s1;
        logic [15:0] in_s2;
        logic [1:0]  diff_s;
    } dcd_st_t;

    dcd_st_t st_q;
    dcd_st_t st_d;
    logic    conv_ready;
    logic    conv_start;
    logic    done_pulse;
    logic    pace_pulse;

    assign done_pulse = st_q.done_s[1] && !st_q.done_last;
    assign pace_pulse = st_q.pace_s[1] && !st_q.pace_last;

    dcd_conv_ctl u_conv
    (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_sw_mode    (st_q.mode[dcd_pkg::SW_BIT]),
        .i_pace_mode  (st_q.mode[dcd_pkg::PACE_BIT]),
        .i_sw_trig    (st_q.sw_trig),
        .i_pace_pulse (pace_pulse),
        .i_done       (done_pulse),
        .o_start      (conv_start),
        .o_ready      (conv_ready)
    );

    always_comb
    begin
        st_d           = st_q;
        st_d.sw_trig   = 1'b0;
        // pins cross two flops before use; host reads of the lines take the second
        st_d.in_s1     = i_in_lines;
        st_d.in_s2     = st_q.in_s1;
        // the input-type strap is a pin too, so it is synchronised
        st_d.diff_s    = {st_q.diff_s[0], i_diff_mode};
        st_d.pace_s    = {st_q.pace_s[0], i_pacer};
        st_d.pace_last = st_q.pace_s[1];
        st_d.done_s    = {st_q.done_s[0], i_conv_done};
        st_d.done_last = st_q.done_s[1];
        // result captured once at completion so a read never tears
        if (done_pulse)
            st_d.result = i_sample_bits;
        st_d.rdata = 8'h00;
        if (i_bus.rd)
        begin
            case (i_bus.addr)
                dcd_pkg::OFF_CONV_DATA:
                    st_d.rdata = st_q.result[7:0];
                dcd_pkg::OFF_CONV_HIGH:
                    st_d.rdata = {4'h0, st_q.result[11:8]};
                dcd_pkg::OFF_LINES_LOW:
                    st_d.rdata = st_q.in_s2[7:0];
                dcd_pkg::OFF_LINES_HIGH:
                    st_d.rdata = st_q.in_s2[15:8];
                dcd_pkg::OFF_CONV_STAT:
                    st_d.rdata = {7'h00, conv_ready};
                dcd_pkg::OFF_CARD_RESET:
                    st_d.rdata = {7'h00, st_q.card_run};
                default:
                    st_d.rdata = 8'h00;
            endcase
        end
        // write path never touches the conversion result or the sampled input lines
        if (i_bus.wr)
        begin
            case (i_bus.addr)
                dcd_pkg::OFF_CONV_DATA:
                    st_d.dac_stage = i_bus.wdata;
                dcd_pkg::OFF_CONV_HIGH:
                    st_d.dac_code = {i_bus.wdata[3:0],
                                     st_q.dac_stage};
                dcd_pkg::OFF_LINES_LOW:
                    if (st_q.card_run)
                        st_d.out_lines[7:0] = i_bus.wdata;
                dcd_pkg::OFF_LINES_HIGH:
                    if (st_q.card_run)
                        st_d.out_lines[15:8] = i_bus.wdata;
                dcd_pkg::OFF_GAIN_CHAN:
                    st_d.sel = i_bus.wdata[5:0];
                dcd_pkg::OFF_TRIG_MODE:
                    st_d.mode = i_bus.wdata[1:0];
                dcd_pkg::OFF_SW_TRIGGER:
                    st_d.sw_trig = i_bus.wdata[dcd_pkg::TRIG_BIT];
                dcd_pkg::OFF_CARD_RESET:
                    st_d.card_run = i_bus.wdata[dcd_pkg::RST_BIT];
                default:
                    st_d.sw_trig = 1'b0;
            endcase
        end
        // differential inputs only have eight pairs
        st_d.chan_eff = st_d.sel[dcd_pkg::CHAN_LSB +: 4];
        if (st_q.diff_s[1])
            st_d.chan_eff[3] = 1'b0;
        if (HIGH_GAIN)
            st_d.gain_f =
                dcd_pkg::GAIN_HI_TAB[st_d.sel[dcd_pkg::GAIN_LSB +: 2]];
        else
            st_d.gain_f =
                dcd_pkg::GAIN_LO_TAB[st_d.sel[dcd_pkg::GAIN_LSB +: 2]];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_q        <= '0;
            st_q.gain_f <= dcd_pkg::GAIN_LO_TAB[0];
        end
        else
            st_q <= st_d;
    end

    assign o_rdata                = st_q.rdata;
    assign o_dac_code             = st_q.dac_code;
    assign o_out_lines            = st_q.out_lines;
    assign o_input_channel_select = st_q.chan_eff;
    assign o_amp_gain_sel_hi      = st_q.sel[1];
    assign o_amp_gain_sel_lo      = st_q.sel[0];
    assign o_gain_factor          = st_q.gain_f;
    assign o_conv_start           = conv_start;

    dac_double_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && i_bus.addr == dcd_pkg::OFF_CONV_DATA)
        |=> $stable(o_dac_code))
        else $error("output code changed on low byte write");
    dac_load_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && i_bus.addr == dcd_pkg::OFF_CONV_HIGH)
        |=> o_dac_code == {$past(i_bus.wdata[3:0]),
                           $past(st_q.dac_stage)})
        else $error("output code not loaded from stage");
    hi_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == dcd_pkg::OFF_CONV_HIGH)
        |=> o_rdata[7:4] == 4'h0)
        else $error("result high nibble upper bits not zero");
    stat_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == dcd_pkg::OFF_CONV_STAT)
        |=> o_rdata == {7'h00, $past(conv_ready)})
        else $error("status read wrong");
    lines_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !st_q.card_run |=> $stable(o_out_lines))
        else $error("output lines moved while card held in reset");
    chan_diff_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_q.diff_s[1]
        |=> !o_input_channel_select[3])
        else $error("top channel bit used in differential mode");
    result_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && !done_pulse) |=> $stable(st_q.result))
        else $error("write altered conversion result");

    // read data stands one cycle only, so an idle port must read zero
    rd_idle_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_bus.rd
        |=> o_rdata == 8'h00)
        else $error("read data not cleared when idle");

    lo_read_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == dcd_pkg::OFF_CONV_DATA)
        |=> o_rdata == $past(st_q.result[7:0]))
        else $error("result low byte read wrong");

    in_lo_read_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == dcd_pkg::OFF_LINES_LOW)
        |=> o_rdata == $past(st_q.in_s2[7:0]))
        else $error("input lines low byte read wrong");

    in_hi_read_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == dcd_pkg::OFF_LINES_HIGH)
        |=> o_rdata == $past(st_q.in_s2[15:8]))
        else $error("input lines high byte read wrong");

    card_rd_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == dcd_pkg::OFF_CARD_RESET)
        |=> o_rdata == {7'h00, $past(st_q.card_run)})
        else $error("card run bit read wrong");

    out_lo_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && i_bus.addr == dcd_pkg::OFF_LINES_LOW && st_q.card_run)
        |=> o_out_lines[7:0] == $past(i_bus.wdata))
        else $error("output lines low byte not written");

    out_hi_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && i_bus.addr == dcd_pkg::OFF_LINES_HIGH && st_q.card_run)
        |=> o_out_lines[15:8] == $past(i_bus.wdata))
        else $error("output lines high byte not written");

    lines_hold_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_bus.wr
        |=> $stable(o_out_lines))
        else $error("output lines moved without a write");

    dac_hold_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !(i_bus.wr && i_bus.addr == dcd_pkg::OFF_CONV_HIGH)
        |=> $stable(o_dac_code))
        else $error("output code moved without nibble write");

    sel_wr_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && i_bus.addr == dcd_pkg::OFF_GAIN_CHAN)
        |=> {o_amp_gain_sel_hi, o_amp_gain_sel_lo} == $past(i_bus.wdata[1:0]))
        else $error("gain code not written");

    gsel_hold_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !(i_bus.wr && i_bus.addr == dcd_pkg::OFF_GAIN_CHAN)
        |=> $stable({o_amp_gain_sel_hi, o_amp_gain_sel_lo}))
        else $error("gain code moved without a write");

    chan_se_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (!st_q.diff_s[1] && i_bus.wr && i_bus.addr == dcd_pkg::OFF_GAIN_CHAN)
        |=> o_input_channel_select == $past(i_bus.wdata[5:2]))
        else $error("single-ended channel not taken whole");

    gain_one_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ({o_amp_gain_sel_hi, o_amp_gain_sel_lo} == 2'b00)
        |-> o_gain_factor == dcd_pkg::GAIN_LO_TAB[0])
        else $error("unity gain code gives wrong factor");

    gain_top_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ({o_amp_gain_sel_hi, o_amp_gain_sel_lo} == 2'b11)
        |-> o_gain_factor == (HIGH_GAIN ? dcd_pkg::GAIN_HI_TAB[3]
                                        : dcd_pkg::GAIN_LO_TAB[3]))
        else $error("top gain code gives wrong factor");

    result_cap_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        done_pulse
        |=> st_q.result == $past(i_sample_bits))
        else $error("result not captured at completion");

    mode_wr_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && i_bus.addr == dcd_pkg::OFF_TRIG_MODE)
        |=> st_q.mode == $past(i_bus.wdata[1:0]))
        else $error("trigger mode not written");

    mode_hold_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !(i_bus.wr && i_bus.addr == dcd_pkg::OFF_TRIG_MODE)
        |=> $stable(st_q.mode))
        else $error("trigger mode moved without a write");

    trig_set_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && i_bus.addr == dcd_pkg::OFF_SW_TRIGGER)
        |=> st_q.sw_trig == $past(i_bus.wdata[dcd_pkg::TRIG_BIT]))
        else $error("software trigger not taken");

    no_trig_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !(i_bus.wr && i_bus.addr == dcd_pkg::OFF_SW_TRIGGER)
        |=> !st_q.sw_trig)
        else $error("software trigger without a write");

    start_pulse_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        o_conv_start
        |=> !o_conv_start)
        else $error("start longer than one cycle");

    // the first edge after release still shows the reset image
    reset_clear_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        $past(i_sys_rst)
        |-> (o_out_lines == '0 && o_dac_code == '0
             && st_q.sel == '0 && st_q.mode == '0))
        else $error("state not cleared by reset");
    c_dac: cover property (@(posedge i_clk) i_bus.wr
        && i_bus.addr == dcd_pkg::OFF_CONV_DATA ##[1:4] i_bus.wr
        && i_bus.addr == dcd_pkg::OFF_CONV_HIGH);
    c_dout: cover property (@(posedge i_clk) $changed(o_out_lines));
endmodule

//--- sim/dcd_conv_model.sv
// behavioural converter seen from the register block's far side
// assumes start is a one-cycle pulse on the same clock as the block
`timescale 1ns/1ps
module dcd_conv_model
#(
    parameter int LAT = 12
)
(
    // clock
    input  wire logic        i_clk,
    // control from the block
    input  wire logic        i_start,
    // value the bench wants converted
    input  wire logic [11:0] i_value,
    // results to the block
    output logic             o_done,
    output logic [11:0]      o_sample_bits
);
    int cnt = 0;

    initial o_done = 1'b0;

    always @(posedge i_clk)
    begin
        if (i_start)
        begin
            o_done <= 1'b0;
            cnt    <= LAT;
        end
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            if (cnt == 1)
                o_done <= 1'b1;
        end
    end

    // data is only valid while done is high; the inverse shows otherwise
    assign o_sample_bits = o_done ? i_value : ~i_value;
endmodule

//--- sim/test_daq_converter_dio_regs.sv
// self-checking bench for the converter and digital I/O register block
// assumes the converter model answers each start after a fixed delay
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_daq_converter_dio_regs;
    logic              i_clk;
    logic              i_sys_rst;
    dcd_pkg::dcd_bus_t bus;
    logic [7:0]        rdata;
    logic [11:0]       sample;
    logic [11:0]       value;
    logic              done;
    logic              pacer;
    logic              diff;
    logic              start;
    logic [11:0]       dac;
    logic [3:0]        chan;
    logic              ghi;
    logic              glo;
    logic [9:0]        gfac;
    logic [9:0]        gfac_hi;
    logic [15:0]       in_lines;
    logic [15:0]       out_lines;
    int                num_errors  = 0;
    int                check_count = 0;
    int                starts      = 0;
    int                cycles      = 0;
    // 23 us of gain settling for code 00 at 25 ns a cycle
    localparam int     SETTLE_CYC  = 920;

    dcd_regs dcd_regs_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_bus(bus), .o_rdata(rdata), .i_sample_bits(sample),
        .i_conv_done(done), .i_pacer(pacer), .i_diff_mode(diff),
        .o_conv_start(start), .o_dac_code(dac),
        .o_input_channel_select(chan), .o_amp_gain_sel_hi(ghi),
        .o_amp_gain_sel_lo(glo), .o_gain_factor(gfac),
        .i_in_lines(in_lines), .o_out_lines(out_lines));

    // high-gain variant, watched only for its gain factor
    dcd_regs #(.HIGH_GAIN(1'b1)) dcd_regs_hi_inst (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(),
        .i_sample_bits(sample), .i_conv_done(done), .i_pacer(pacer),
        .i_diff_mode(diff), .o_conv_start(), .o_dac_code(),
        .o_input_channel_select(), .o_amp_gain_sel_hi(),
        .o_amp_gain_sel_lo(), .o_gain_factor(gfac_hi),
        .i_in_lines(in_lines), .o_out_lines());

    dcd_conv_model dcd_conv_model_inst (.i_clk(i_clk), .i_start(start),
        .i_value(value), .o_done(done), .o_sample_bits(sample));

    always #12.5 i_clk = ~i_clk;

    always @(posedge i_clk)
    begin
        if (start === 1'b1)
            starts <= starts + 1;
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one-cycle write strobe; effect is visible after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk);
        bus <= '0;
        #1;
    endtask

    // read data stands for the one cycle after the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_clk);
        bus <= '0;
        #1;
        `CHK(rdata, e)
    endtask

    initial
    begin
        logic [9:0] lo_tab [4];
        logic [9:0] hi_tab [4];
        lo_tab = '{10'd1, 10'd2, 10'd4, 10'd8};
        hi_tab = '{10'd1, 10'd10, 10'd100, 10'd1000};
        i_clk = 1'b0;
        i_sys_rst = 1'b1;
        bus = '0;
        value = 12'h000;
        pacer = 1'b0;
        diff = 1'b0;
        in_lines = 16'h0000;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        `CHK(out_lines, 16'h0000)
        `CHK({dac, chan, ghi, glo}, 18'h00000)
        rd(8'hec, 8'h00);
        $display("test reset done");
        // output lines stay dead until the card-run bit is set
        wr(8'hd8, 8'ha5);
        `CHK(out_lines, 16'h0000)
        wr(8'h00, 8'h01);
        rd(8'h00, 8'h01);
        wr(8'hd8, 8'ha5);
        wr(8'hdc, 8'h3c);
        `CHK(out_lines, 16'h3ca5)
        in_lines <= 16'h5a69;
        repeat (3) @(posedge i_clk);
        rd(8'hd8, 8'h69);
        rd(8'hdc, 8'h5a);
        rd(8'h44, 8'h00);
        $display("test digital lines done");
        wr(8'hd0, 8'hc3);
        `CHK(dac, 12'h000)
        wr(8'hd4, 8'hf7);
        `CHK(dac, 12'h7c3)
        wr(8'hd0, 8'h11);
        `CHK(dac, 12'h7c3)
        $display("test output code done");
        for (int g = 0; g < 4; g++)
        begin
            wr(8'he0, {2'b11, 4'(9 + g), 2'(g)});
            `CHK({chan, ghi, glo}, {4'(9 + g), 2'(g)})
            `CHK(gfac, lo_tab[g])
            `CHK(gfac_hi, hi_tab[g])
        end
        diff <= 1'b1;
        // the strap passes two flops before the channel logic sees it
        repeat (2) @(posedge i_clk);
        wr(8'he0, 8'h3c);
        `CHK(chan, 4'h7)
        diff <= 1'b0;
        repeat (SETTLE_CYC) @(posedge i_clk);
        $display("test gain and channel done");
        value <= 12'h9b6;
        wr(8'he4, 8'hf1);
        wr(8'he8, 8'h01);
        wr(8'he8, 8'h01);
        rd(8'hec, 8'h00);
        repeat (20) @(posedge i_clk);
        rd(8'hec, 8'h01);
        rd(8'hd0, 8'hb6);
        rd(8'hd4, 8'h09);
        `CHK(starts, 1)
        $display("test software trigger done");
        value <= 12'h5e4;
        wr(8'he4, 8'hf2);
        wr(8'he8, 8'h01);
        repeat (20) @(posedge i_clk);
        `CHK(starts, 1)
        pacer <= 1'b1;
        repeat (4) @(posedge i_clk);
        pacer <= 1'b0;
        repeat (30) @(posedge i_clk);
        `CHK(starts, 2)
        rd(8'hd0, 8'he4);
        $display("test pacer trigger done");
        test_done();
    end
endmodule
